// File: src/sdcd_decoder.sv
// Command and clock-enable decoder of a synchronous DRAM device.
`include "sdcd_regs.svh"

module sdcd_decoder #(
  parameter int ADDR_BITS       = 15,
  parameter int ROW_BITS        = 15,
  parameter int COL_BITS        = 10,
  parameter int CAL_LONG_CYCLES = `SDCD_CAL_LONG_CYCLES,
  parameter int CAL_SHORT_CYCLES = `SDCD_CAL_SHORT_CYCLES,
  parameter int EXIT_CYCLES     = `SDCD_EXIT_CYCLES
) (
  input  wire logic                    mclk_in,
  input  wire logic                    rst_in,
  input  wire logic                    reset_n_in,
  input  wire logic                    cke_in,
  input  wire logic                    cs_n_in,
  input  wire logic                    ras_n_in,
  input  wire logic                    cas_n_in,
  input  wire logic                    we_n_in,
  input  wire logic [2:0]              ba_in,
  input  wire logic [ADDR_BITS-1:0]    addr_in,
  input  wire logic                    termination_control_in,
  output sdcd_pkg::sdcd_cmd_e          cmd_out,
  output logic                         illegal_out,
  output logic                         autoclose_out,
  output logic                         chop_out,
  output logic [2:0]                   bank_out,
  output logic [ROW_BITS-1:0]          row_out,
  output logic [COL_BITS-1:0]          col_out,
  output sdcd_pkg::sdcd_state_e        state_out,
  output logic [7:0]                   open_banks_out,
  output logic                         burst_active_out,
  output logic                         idle_out,
  output logic                         init_cal_out,
  output logic                         oper_cal_out,
  output logic [ROW_BITS-1:0]          refresh_row_out,
  output logic                         termination_control_out
);
  localparam int SW = 10 + ADDR_BITS;

  typedef struct packed {
    logic                  cke_prev;
    sdcd_pkg::sdcd_cmd_e   cmd;
    logic                  illegal;
    logic                  autoclose;
    logic                  chop;
    logic [2:0]            bank;
    logic [ROW_BITS-1:0]   row;
    logic [COL_BITS-1:0]   col;
    sdcd_pkg::sdcd_state_e state;
    logic [7:0]            banks;
    logic [2:0]            burst_cnt;
    logic [2:0]            burst_bank;
    logic                  burst_close;
    logic                  burst_act;
    logic                  idle;
    logic                  init_cal;
    logic                  oper_cal;
    logic                  cal_seen;
    logic [`SDCD_CNT_W-1:0] busy_cnt;
    logic [ROW_BITS-1:0]   refresh_row;
    logic                  term;
    logic                  mr_we;
    logic [1:0]            mr_sel;
    logic [ADDR_BITS-1:0]  mr_data;
  } sdcd_dec_s;

  sdcd_dec_s s_q;
  sdcd_dec_s n;

  // ****************************************************************
  // Pin synchronisers and mode register store
  // ****************************************************************
  logic [SW-1:0]        pins;
  logic                 pin_reset_n;
  logic                 pin_cke;
  logic                 pin_cs_n;
  logic                 pin_ras_n;
  logic                 pin_cas_n;
  logic                 pin_we_n;
  logic                 pin_term;
  logic [2:0]           pin_ba;
  logic [ADDR_BITS-1:0] pin_addr;
  logic                 nop_like;

  sdcd_sync #(.W(SW)) u_sync (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .d_in    ({reset_n_in, cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in,
               termination_control_in, ba_in, addr_in}),
    .q_out   (pins)
  );

  assign {pin_reset_n, pin_cke, pin_cs_n, pin_ras_n, pin_cas_n, pin_we_n,
          pin_term, pin_ba, pin_addr} = pins;
  assign nop_like = pin_cs_n | (pin_ras_n & pin_cas_n & pin_we_n);

  sdcd_mr_if #(.W(ADDR_BITS)) mr_bus ();

  sdcd_mode_mem #(.W(ADDR_BITS)) u_mem (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .mr      (mr_bus.mem)
  );

  assign mr_bus.wr_en   = s_q.mr_we;
  assign mr_bus.wr_sel  = s_q.mr_sel;
  assign mr_bus.wr_data = s_q.mr_data;
  assign mr_bus.rd_sel  = 2'h0;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic sdcd_pkg::sdcd_cmd_e decode_cmd(
    input logic ck_prev, input logic ck_now, input logic cs_n, input logic ras_n,
    input logic cas_n, input logic we_n, input logic sel10, input logic chop);
    logic quiet;
    quiet      = cs_n | (ras_n & cas_n & we_n);
    decode_cmd = sdcd_pkg::CMD_ILLEGAL;
    if (!ck_prev) begin
      if (!ck_now) begin
        decode_cmd = sdcd_pkg::CMD_STATE_HOLD;
      end else if (quiet) begin
        decode_cmd = sdcd_pkg::CMD_WAKE;
      end
    end else if (!ck_now) begin
      if (quiet) begin
        decode_cmd = sdcd_pkg::CMD_POWERDOWN_ENTRY;
      end else if ({ras_n, cas_n, we_n} == 3'h1) begin
        decode_cmd = sdcd_pkg::CMD_SELF_REFRESH_ENTRY;
      end
    end else if (cs_n) begin
      decode_cmd = sdcd_pkg::CMD_DESELECT;
    end else begin
      case ({ras_n, cas_n, we_n})
        3'h0: decode_cmd = sdcd_pkg::CMD_MODE_SET;
        3'h1: decode_cmd = sdcd_pkg::CMD_REFRESH;
        3'h2: decode_cmd = sel10 ? sdcd_pkg::CMD_ALL_BANKS_CLOSE : sdcd_pkg::CMD_PRECHARGE;
        3'h3: decode_cmd = sdcd_pkg::CMD_ROW_OPEN;
        3'h4: decode_cmd = chop ? sdcd_pkg::CMD_WRITE_CHOP : sdcd_pkg::CMD_WRITE_FULL;
        3'h5: decode_cmd = chop ? sdcd_pkg::CMD_READ_CHOP : sdcd_pkg::CMD_READ_FULL;
        3'h6: decode_cmd = sel10 ? sdcd_pkg::CMD_LONG_CALIBRATION
                                 : sdcd_pkg::CMD_SHORT_CALIBRATION;
        default: decode_cmd = sdcd_pkg::CMD_NO_OPERATION;
      endcase
    end
  endfunction

  // Wide parts take the column high bit from A11, skipping the precharge select bit.
  function automatic logic [COL_BITS-1:0] col_of(input logic [ADDR_BITS-1:0] a);
    logic [11:0] c;
    c = {1'b0, a[`SDCD_COL_HIGH_BIT], a[9:0]};
    if (COL_BITS <= 10) begin
      c[10] = 1'b0;
    end
    col_of = c[COL_BITS-1:0];
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic [1:0] burst_mode;
  logic       chop_sel;
  logic       sel10;
  logic       awake;
  logic       quiet_banks;
  logic       is_read;

  assign burst_mode = mr_bus.rd_data[`SDCD_MR0_BURST_LSB +: 2];
  assign sel10      = pin_addr[`SDCD_PRECHARGE_SELECT_BIT];
  assign chop_sel   = (burst_mode == `SDCD_BURST_FIXED_CHOP) ||
                      ((burst_mode == `SDCD_BURST_PER_COMMAND) &&
                       !pin_addr[`SDCD_BURST_CHOP_SELECT_BIT]);

  always_comb begin
    n           = s_q;
    n.cke_prev  = pin_cke;
    n.term      = pin_term;
    n.illegal   = 1'b0;
    n.autoclose = 1'b0;
    n.init_cal  = 1'b0;
    n.oper_cal  = 1'b0;
    n.mr_we     = 1'b0;
    n.bank      = pin_ba;
    n.row       = pin_addr[ROW_BITS-1:0];
    n.col       = col_of(pin_addr);
    n.chop      = chop_sel;
    n.cmd       = decode_cmd(s_q.cke_prev, pin_cke, pin_cs_n, pin_ras_n, pin_cas_n,
                             pin_we_n, sel10, chop_sel);
    if (s_q.busy_cnt != '0) begin
      n.busy_cnt = s_q.busy_cnt - `SDCD_CNT_W'(1);
    end
    // A burst counts down untouched by later commands except a read or write in its last cycle, and may close its row at the end.
    if (s_q.burst_cnt != 3'h0) begin
      n.burst_cnt = s_q.burst_cnt - 3'h1;
      if (s_q.burst_cnt == 3'h1 && s_q.burst_close) begin
        n.banks[s_q.burst_bank] = 1'b0;
      end
    end
    awake       = s_q.state == sdcd_pkg::ST_AWAKE;
    quiet_banks = awake && n.banks == 8'h00 && n.burst_cnt == 3'h0;
    is_read     = n.cmd == sdcd_pkg::CMD_READ_CHOP || n.cmd == sdcd_pkg::CMD_READ_FULL;
    case (n.cmd)
      sdcd_pkg::CMD_DESELECT, sdcd_pkg::CMD_NO_OPERATION: begin
        n.illegal = !awake;
      end
      sdcd_pkg::CMD_STATE_HOLD: begin
        n.illegal = awake;
      end
      sdcd_pkg::CMD_WAKE: begin
        if (s_q.state == sdcd_pkg::ST_SELF_REFRESH) begin
          n.cmd = sdcd_pkg::CMD_SELF_REFRESH_EXIT;
        end else begin
          n.cmd = sdcd_pkg::CMD_POWERDOWN_EXIT;
        end
        n.illegal = awake;
        if (!awake) begin
          n.state    = sdcd_pkg::ST_AWAKE;
          n.busy_cnt = `SDCD_CNT_W'(EXIT_CYCLES);
        end
      end
      sdcd_pkg::CMD_POWERDOWN_ENTRY: begin
        n.illegal = !awake;
        if (awake) begin
          n.state = (n.banks != 8'h00) ? sdcd_pkg::ST_PD_ACTIVE
                                       : sdcd_pkg::ST_PD_PRECHARGE;
        end
      end
      sdcd_pkg::CMD_SELF_REFRESH_ENTRY: begin
        n.illegal = !quiet_banks;
        if (quiet_banks) begin
          n.state = sdcd_pkg::ST_SELF_REFRESH;
        end
      end
      sdcd_pkg::CMD_MODE_SET: begin
        n.illegal = !quiet_banks;
        n.mr_we   = quiet_banks;
        n.mr_sel  = pin_ba[1:0];
        n.mr_data = pin_addr;
      end
      sdcd_pkg::CMD_REFRESH: begin
        n.illegal = !quiet_banks;
        n.row     = s_q.refresh_row;
        if (quiet_banks) begin
          n.refresh_row = s_q.refresh_row + ROW_BITS'(1);
        end
      end
      sdcd_pkg::CMD_PRECHARGE: begin
        n.illegal = !awake;
        if (awake) begin
          n.banks[pin_ba] = 1'b0;
        end
      end
      sdcd_pkg::CMD_ALL_BANKS_CLOSE: begin
        n.illegal = !awake;
        if (awake) begin
          n.banks = 8'h00;
        end
      end
      sdcd_pkg::CMD_ROW_OPEN: begin
        n.illegal = !awake || n.banks[pin_ba];
        if (!n.illegal) begin
          n.banks[pin_ba] = 1'b1;
        end
      end
      sdcd_pkg::CMD_WRITE_CHOP, sdcd_pkg::CMD_WRITE_FULL, sdcd_pkg::CMD_READ_CHOP,
      sdcd_pkg::CMD_READ_FULL: begin
        n.illegal   = !awake || !n.banks[pin_ba] || s_q.burst_cnt > 3'h1;
        n.autoclose = sel10;
        if (!n.illegal) begin
          n.burst_cnt   = chop_sel ? `SDCD_BURST_CLKS_CHOP : `SDCD_BURST_CLKS_EIGHT;
          n.burst_bank  = pin_ba;
          n.burst_close = sel10;
        end
      end
      sdcd_pkg::CMD_LONG_CALIBRATION, sdcd_pkg::CMD_SHORT_CALIBRATION: begin
        n.illegal = !quiet_banks;
        if (quiet_banks) begin
          if (n.cmd == sdcd_pkg::CMD_SHORT_CALIBRATION) begin
            n.busy_cnt = `SDCD_CNT_W'(CAL_SHORT_CYCLES);
          end else begin
            n.busy_cnt = `SDCD_CNT_W'(CAL_LONG_CYCLES);
            n.init_cal = !s_q.cal_seen;
            n.oper_cal = s_q.cal_seen;
            n.cal_seen = 1'b1;
          end
        end
      end
      default: begin
        n.illegal = 1'b1;
      end
    endcase
    n.idle = n.state == sdcd_pkg::ST_AWAKE && n.banks == 8'h00 && n.burst_cnt == 3'h0 &&
             pin_cke && n.busy_cnt == '0;
    n.burst_act = n.burst_cnt != 3'h0;
    if (!pin_reset_n) begin
      n = '0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= n;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign cmd_out                 = s_q.cmd;
  assign illegal_out             = s_q.illegal;
  assign autoclose_out           = s_q.autoclose;
  assign chop_out                = s_q.chop;
  assign bank_out                = s_q.bank;
  assign row_out                 = s_q.row;
  assign col_out                 = s_q.col;
  assign state_out               = s_q.state;
  assign open_banks_out          = s_q.banks;
  assign burst_active_out        = s_q.burst_act;
  assign idle_out                = s_q.idle;
  assign init_cal_out            = s_q.init_cal;
  assign oper_cal_out            = s_q.oper_cal;
  assign refresh_row_out         = s_q.refresh_row;
  assign termination_control_out = s_q.term;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in || !pin_reset_n);

  sequence s_full_start;
    (s_q.cmd == sdcd_pkg::CMD_READ_FULL || s_q.cmd == sdcd_pkg::CMD_WRITE_FULL) &&
    !s_q.illegal;
  endsequence

  sequence s_sr_exit_req;
    s_q.state == sdcd_pkg::ST_SELF_REFRESH && !s_q.cke_prev && pin_cke && nop_like;
  endsequence

  property p_deselect;
    s_q.cke_prev && pin_cke && pin_cs_n |=> s_q.cmd == sdcd_pkg::CMD_DESELECT;
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect not decoded");

  property p_sr_entry_busy;
    s_q.cke_prev && !pin_cke && !pin_cs_n && !pin_ras_n && !pin_cas_n && pin_we_n &&
    s_q.banks != 8'h00 |=> s_q.illegal && s_q.state != sdcd_pkg::ST_SELF_REFRESH;
  endproperty
  a_sr_entry_busy: assert property (p_sr_entry_busy) else $error("self refresh with open bank");

  property p_sr_exit;
    s_sr_exit_req |=> s_q.cmd == sdcd_pkg::CMD_SELF_REFRESH_EXIT &&
                      s_q.state == sdcd_pkg::ST_AWAKE ##1 !s_q.idle;
  endproperty
  a_sr_exit: assert property (p_sr_exit) else $error("self refresh exit missed");

  property p_pd_hold;
    s_q.state != sdcd_pkg::ST_AWAKE && !s_q.cke_prev && !pin_cke |=>
      $stable(s_q.state) && $stable(s_q.banks);
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("low clock enable changed state");

  property p_pd_active_entry;
    s_q.state == sdcd_pkg::ST_AWAKE && s_q.cke_prev && !pin_cke && nop_like &&
    s_q.banks != 8'h00 && s_q.burst_cnt == 3'h0 |=> s_q.state == sdcd_pkg::ST_PD_ACTIVE;
  endproperty
  a_pd_active_entry: assert property (p_pd_active_entry) else $error("active power-down missed");

  property p_no_refresh_pd;
    s_q.state == sdcd_pkg::ST_PD_ACTIVE || s_q.state == sdcd_pkg::ST_PD_PRECHARGE |=>
      $stable(s_q.refresh_row);
  endproperty
  a_no_refresh_pd: assert property (p_no_refresh_pd) else $error("refresh in power-down");

  property p_burst_runs;
    s_full_start |-> (s_q.burst_cnt != 3'h0) [*4] ##1
      (s_q.burst_cnt == 3'h0 || (!s_q.illegal && (s_q.cmd == sdcd_pkg::CMD_READ_FULL ||
       s_q.cmd == sdcd_pkg::CMD_WRITE_FULL || s_q.cmd == sdcd_pkg::CMD_READ_CHOP ||
       s_q.cmd == sdcd_pkg::CMD_WRITE_CHOP)));
  endproperty
  a_burst_runs: assert property (p_burst_runs) else $error("burst cut short");

  property p_autoclose;
    s_full_start and (s_q.cmd == sdcd_pkg::CMD_READ_FULL && s_q.burst_close) |->
      ##4 !s_q.banks[s_q.burst_bank];
  endproperty
  a_autoclose: assert property (p_autoclose) else $error("autoclose row left open");

  property p_first_cal;
    s_q.cmd == sdcd_pkg::CMD_LONG_CALIBRATION && !s_q.illegal && !$past(s_q.cal_seen) |->
      s_q.init_cal && !s_q.oper_cal;
  endproperty
  a_first_cal: assert property (p_first_cal) else $error("initial calibration not flagged");

  property p_refresh_addr;
    s_q.cmd == sdcd_pkg::CMD_REFRESH && !s_q.illegal |->
      s_q.refresh_row == s_q.row + ROW_BITS'(1);
  endproperty
  a_refresh_addr: assert property (p_refresh_addr) else $error("refresh row not internal");

  property p_illegal_flag;
    s_q.cmd == sdcd_pkg::CMD_ILLEGAL |-> s_q.illegal && !s_q.mr_we;
  endproperty
  a_illegal_flag: assert property (p_illegal_flag) else $error("illegal pattern not flagged");
endmodule

// File: src/sdcd_mode_mem.sv
// Store of the four mode registers with a registered read port.
`include "sdcd_regs.svh"

module sdcd_mode_mem #(
  parameter int W = 15
) (
  input  wire logic mclk_in,
  input  wire logic rst_in,
  sdcd_mr_if.mem    mr
);
  typedef struct packed {
    logic [`SDCD_MODE_REG_COUNT-1:0][W-1:0] regs;
    logic [W-1:0]                           rdata;
  } sdcd_mem_s;

  sdcd_mem_s s_q;
  sdcd_mem_s s_d;

  always_comb begin
    s_d = s_q;
    if (mr.wr_en) begin
      s_d.regs[mr.wr_sel] = mr.wr_data;
    end
    s_d.rdata = s_q.regs[mr.rd_sel];
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_q <= {`SDCD_MODE_REG_COUNT + 1{W'(`SDCD_MODE_REG_RESET)}};
    end else begin
      s_q <= s_d;
    end
  end

  assign mr.rd_data = s_q.rdata;
endmodule

// File: src/sdcd_mr_if.sv
// Interface between the decoder and its mode register store.
interface sdcd_mr_if #(
  parameter int W = 15
);
  logic         wr_en;
  logic [1:0]   wr_sel;
  logic [W-1:0] wr_data;
  logic [1:0]   rd_sel;
  logic [W-1:0] rd_data;

  modport ctl (output wr_en, output wr_sel, output wr_data, output rd_sel, input rd_data);
  modport mem (input wr_en, input wr_sel, input wr_data, input rd_sel, output rd_data);
endinterface

// File: src/sdcd_pkg.sv
// Types shared by the synchronous DRAM command decoder modules.
package sdcd_pkg;

  // ****************************************************************
  // Decoded commands
  // ****************************************************************
  typedef enum logic [4:0] {
    CMD_DESELECT,
    CMD_NO_OPERATION,
    CMD_MODE_SET,
    CMD_REFRESH,
    CMD_SELF_REFRESH_ENTRY,
    CMD_SELF_REFRESH_EXIT,
    CMD_POWERDOWN_ENTRY,
    CMD_POWERDOWN_EXIT,
    CMD_STATE_HOLD,
    CMD_WAKE,
    CMD_PRECHARGE,
    CMD_ALL_BANKS_CLOSE,
    CMD_ROW_OPEN,
    CMD_WRITE_CHOP,
    CMD_WRITE_FULL,
    CMD_READ_CHOP,
    CMD_READ_FULL,
    CMD_LONG_CALIBRATION,
    CMD_SHORT_CALIBRATION,
    CMD_ILLEGAL
  } sdcd_cmd_e;

  // ****************************************************************
  // Device power state
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_AWAKE,
    ST_PD_ACTIVE,
    ST_PD_PRECHARGE,
    ST_SELF_REFRESH
  } sdcd_state_e;

endpackage

// File: src/sdcd_regs.svh
// Constants of the synchronous DRAM command decoder: fields, reset values and counts.
`ifndef SDCD_REGS_SVH
`define SDCD_REGS_SVH

// ****************************************************************
// Command-bus field positions
// ****************************************************************
`define SDCD_PRECHARGE_SELECT_BIT   10
`define SDCD_BURST_CHOP_SELECT_BIT  12
`define SDCD_COL_HIGH_BIT           11

// ****************************************************************
// First mode register burst field and reset value
// ****************************************************************
`define SDCD_MR0_BURST_LSB          0
`define SDCD_BURST_FIXED_EIGHT      2'h0
`define SDCD_BURST_PER_COMMAND      2'h1
`define SDCD_BURST_FIXED_CHOP       2'h2
`define SDCD_MODE_REG_RESET         16'h0000
`define SDCD_MODE_REG_COUNT         4

// ****************************************************************
// Timing counts in clock cycles and their counter width
// ****************************************************************
`define SDCD_BURST_CLKS_EIGHT       3'h4
`define SDCD_BURST_CLKS_CHOP        3'h2
`define SDCD_CAL_LONG_CYCLES        512
`define SDCD_CAL_SHORT_CYCLES       64
`define SDCD_EXIT_CYCLES            4
`define SDCD_CNT_W                  16

`endif

// File: src/sdcd_sync.sv
// Two-stage synchroniser for the command pins.
module sdcd_sync #(
  parameter int W = 25
) (
  input  wire logic         mclk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } sdcd_sync_s;

  sdcd_sync_s s_q;
  sdcd_sync_s s_d;

  always_comb begin
    s_d        = s_q;
    s_d.stage1 = d_in;
    s_d.stage2 = s_q.stage1;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q_out = s_q.stage2;
endmodule

// File: tb/sdcd_ctl_model.sv
// Controller-side model that turns a command code into the command pins.
module sdcd_ctl_model (
  input  wire logic       mclk_in,
  input  wire logic [3:0] op_in,
  output logic            cs_n_out,
  output logic            ras_n_out,
  output logic            cas_n_out,
  output logic            we_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] junk_q = 3'h5;
  // Deselected strobes are don't-care, so they change every cycle.
  always @(posedge mclk_in) junk_q <= ~junk_q;
  always_comb begin
    cs_n_out = op_in[3];
    {ras_n_out, cas_n_out, we_n_out} = op_in[3] ? junk_q : op_in[2:0];
  end
endmodule

// File: tb/tb_top.sv
// Bench for the command decoder: pin sequences with expected decodes.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst = 1'b1, cke = 1'b0, term = 1'b0;
  logic [3:0] op = 4'h7;
  logic [2:0] ba = 3'h0;
  logic [14:0] addr = 15'h0000;
  logic cs_n, ras_n, cas_n, we_n, ill, ac, icl, ch, tco;
  logic rn = 1'b1;
  logic [7:0] banks;
  sdcd_pkg::sdcd_cmd_e cmd;
  sdcd_pkg::sdcd_state_e st;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  initial forever #5 mclk = ~mclk;
  sdcd_ctl_model mdl_u (.mclk_in(mclk), .op_in(op), .cs_n_out(cs_n), .ras_n_out(ras_n),
    .cas_n_out(cas_n), .we_n_out(we_n));
  sdcd_decoder #(.CAL_LONG_CYCLES(8), .CAL_SHORT_CYCLES(4), .EXIT_CYCLES(2)) dut_u (
    .mclk_in(mclk), .rst_in(rst), .reset_n_in(rn), .cke_in(cke), .cs_n_in(cs_n),
    .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .ba_in(ba), .addr_in(addr),
    .termination_control_in(term), .cmd_out(cmd), .illegal_out(ill), .autoclose_out(ac),
    .chop_out(ch), .bank_out(), .row_out(), .col_out(), .state_out(st),
    .open_banks_out(banks), .burst_active_out(), .idle_out(), .init_cal_out(icl),
    .oper_cal_out(), .refresh_row_out(), .termination_control_out(tco));
  // ********************
  // Shared tasks
  // ********************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  // Drives one command for one edge, then waits for its decode to appear.
  task automatic issue(input logic [3:0] o, input logic c, input logic [2:0] b,
                       input logic [14:0] a);
    cke = c;
    op = o;
    ba = b;
    addr = a;
    term = ~term;
    @(posedge mclk);
    #1 op = 4'h7;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // ********************
  // Main sequence
  // ********************
  initial begin
    repeat (10) @(posedge mclk);
    #1 rst = 1'b0;
    chk(cmd, sdcd_pkg::CMD_DESELECT);
    chk(st, sdcd_pkg::ST_AWAKE);
    issue(4'h7, 1'b1, 3'h0, 15'h0000);
    issue(4'h7, 1'b1, 3'h0, 15'h0000);
    chk(cmd, sdcd_pkg::CMD_NO_OPERATION);
    issue(4'h0, 1'b1, 3'h0, 15'h0001);
    chk(cmd, sdcd_pkg::CMD_MODE_SET);
    issue(4'h6, 1'b1, 3'h0, 15'h0400);
    chk(cmd, sdcd_pkg::CMD_LONG_CALIBRATION);
    chk(icl, 1'b1);
    repeat (10) @(posedge mclk);
    #1;
    issue(4'h6, 1'b1, 3'h0, 15'h0000);
    chk(cmd, sdcd_pkg::CMD_SHORT_CALIBRATION);
    repeat (6) @(posedge mclk);
    #1;
    issue(4'h1, 1'b1, 3'h5, 15'h7FFF);
    chk(cmd, sdcd_pkg::CMD_REFRESH);
    issue(4'h5, 1'b1, 3'h3, 15'h0000);
    chk(ill, 1'b1);
    chk(ch, 1'b1);
    chk(tco, term);
    issue(4'h3, 1'b1, 3'h2, 15'h0000);
    chk(cmd, sdcd_pkg::CMD_ROW_OPEN);
    chk(banks, 8'h04);
    issue(4'h5, 1'b1, 3'h2, 15'h1400);
    chk(cmd, sdcd_pkg::CMD_READ_FULL);
    chk(ac, 1'b1);
    repeat (4) @(posedge mclk);
    #1;
    chk(banks, 8'h00);
    issue(4'h8, 1'b1, 3'h0, 15'h0000);
    chk(cmd, sdcd_pkg::CMD_DESELECT);
    issue(4'h7, 1'b0, 3'h0, 15'h0000);
    chk(cmd, sdcd_pkg::CMD_POWERDOWN_ENTRY);
    chk(st, sdcd_pkg::ST_PD_PRECHARGE);
    issue(4'h0, 1'b0, 3'h0, 15'h0000);
    chk(cmd, sdcd_pkg::CMD_STATE_HOLD);
    issue(4'h7, 1'b1, 3'h0, 15'h0000);
    chk(cmd, sdcd_pkg::CMD_POWERDOWN_EXIT);
    repeat (4) @(posedge mclk);
    #1;
    issue(4'h1, 1'b0, 3'h0, 15'h0000);
    chk(cmd, sdcd_pkg::CMD_SELF_REFRESH_ENTRY);
    chk(st, sdcd_pkg::ST_SELF_REFRESH);
    issue(4'h7, 1'b1, 3'h0, 15'h0000);
    chk(cmd, sdcd_pkg::CMD_SELF_REFRESH_EXIT);
    repeat (4) @(posedge mclk);
    #1;
    issue(4'h3, 1'b1, 3'h1, 15'h0000);
    chk(banks, 8'h02);
    rn = 1'b0;
    issue(4'h7, 1'b1, 3'h0, 15'h0000);
    chk(banks, 8'h00);
    chk(cmd, sdcd_pkg::CMD_DESELECT);
    rn = 1'b1;
    tally_and_finish();
  end
endmodule
